// ### id_auth_regs.svh
// register map and field layout of the identifier input block
// assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef ID_AUTH_REGS_SVH
`define ID_AUTH_REGS_SVH

`define ID_AUTH_ADDR_W 8
`define ID_AUTH_STATUS_OFS 8'h00
`define ID_AUTH_CONTROL_OFS 8'h04
`define ID_AUTH_DF_KEY_BASE 8'h20
`define ID_AUTH_DEBUG_KEY_BASE 8'h40
`define ID_AUTH_BANK_SPAN 8'h20

`define ID_AUTH_STATUS_RESET 32'h0000_0000
`define ID_AUTH_KEY_WORD_RESET 32'h0000_0000

`define ID_AUTH_STAT_DF_DONE 0
`define ID_AUTH_STAT_DF_PASS 1
`define ID_AUTH_STAT_DF_BUSY 2
`define ID_AUTH_STAT_DEBUG_DONE 8
`define ID_AUTH_STAT_DEBUG_PASS 9
`define ID_AUTH_STAT_DEBUG_BUSY 10

`define ID_AUTH_CTRL_DF_RESTART 0
`define ID_AUTH_CTRL_DEBUG_RESTART 1

`define ID_AUTH_FULL_WORD_BE 4'hf
`define ID_AUTH_LAST_WORD 3'h7
`define ID_AUTH_FIRST_WORD 3'h0

`endif

// ### id_auth_pkg.sv
// types shared by the identifier input block
// assumes nothing beyond a SystemVerilog compiler
package id_auth_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_RD_MEM = 2'b01,
    BUS_RD_DONE = 2'b10
  } bus_state_t;

  typedef enum logic [0:0]
  {
    BANK_DF = 1'b0,
    BANK_DEBUG = 1'b1
  } bank_t;

endpackage

// ### key_word_store.sv
// small word memory holding the identifier words written by software
// assumes one write and one read port, read data registered
`timescale 1ns/100ps
`include "id_auth_regs.svh"

module key_word_store
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_data_q;
  logic [WIDTH-1:0] rd_data_d;

  always_comb
  begin
    rd_data_d = rd_data_q;
    if (rd_en)
    begin
      rd_data_d = mem_q[rd_addr];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rd_data_q <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= WIDTH'(`ID_AUTH_KEY_WORD_RESET);
      end
    end
    else
    begin
      rd_data_q <= rd_data_d;
      if (wr_en)
      begin
        mem_q[wr_addr] <= wr_data;
      end
    end
  end

  assign rd_data = rd_data_q;

endmodule

// ### key_order_tracker.sv
// tracks one bank's word sequence and keeps its pass or fail verdict
// assumes each write arrives with its word index and a word-compare result
`timescale 1ns/100ps
`include "id_auth_regs.svh"

module key_order_tracker
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic wr_stb,
  input wire logic [2:0] wr_index,
  input wire logic wr_match,
  output logic auth_done,
  output logic auth_pass,
  output logic auth_busy
);

  logic [2:0] expect_q;
  logic [2:0] expect_d;
  logic ok_q;
  logic ok_d;
  logic done_q;
  logic done_d;
  logic pass_q;
  logic pass_d;
  logic busy_q;
  logic busy_d;
  logic ok_next;

  always_comb
  begin
    expect_d = expect_q;
    ok_d = ok_q;
    done_d = done_q;
    pass_d = pass_q;
    busy_d = busy_q;
    ok_next = 1'b0;
    if (restart)
    begin
      expect_d = `ID_AUTH_FIRST_WORD;
      ok_d = 1'b1;
      done_d = 1'b0;
      pass_d = 1'b0;
      busy_d = 1'b0;
    end
    else if (wr_stb)
    begin
      // any write drops the old verdict
      done_d = 1'b0;
      pass_d = 1'b0;
      if (wr_index == `ID_AUTH_FIRST_WORD)
      begin
        ok_next = wr_match;
      end
      else
      begin
        ok_next = ok_q && busy_q && (wr_index == expect_q) && wr_match;
      end
      if (wr_index == `ID_AUTH_LAST_WORD)
      begin
        // verdict whenever the top word lands; a pass needs the lower seven before it in order
        done_d = 1'b1;
        pass_d = ok_next;
        busy_d = 1'b0;
        expect_d = `ID_AUTH_FIRST_WORD;
        ok_d = 1'b1;
      end
      else
      begin
        busy_d = 1'b1;
        ok_d = ok_next;
        expect_d = 3'(wr_index + 3'h1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      expect_q <= 3'h0;
      ok_q <= 1'b1;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      expect_q <= expect_d;
      ok_q <= ok_d;
      done_q <= done_d;
      pass_q <= pass_d;
      busy_q <= busy_d;
    end
  end

  assign auth_done = done_q;
  assign auth_pass = pass_q;
  assign auth_busy = busy_q;

endmodule

// ### id_auth_input_registers.sv
// identifier input registers for data flash and debug access authentication
// assumes an Avalon-MM master on mclk and stored reference identifiers held
// steady by the security area outside this block
//
// Operation
// - data flash key is the 256-bit bank value compared against stored reference
// - data flash word k carries identifier bits 32k+31 down to 32k
// - debug key is the 256-bit bank value compared against stored reference
// - debug word k carries identifier bits 32k+31 down to 32k
// - debug key words accept only whole 32-bit accesses
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`include "id_auth_regs.svh"

module id_auth_input_registers
#(
  parameter int ID_BITS = 256,
  parameter int WORD_BITS = 32,
  parameter int BANK_WORDS = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`ID_AUTH_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [ID_BITS-1:0] df_reference_id,
  input wire logic [ID_BITS-1:0] debug_reference_id,
  output logic df_auth_done,
  output logic df_auth_pass,
  output logic debug_auth_done,
  output logic debug_auth_pass
);

  localparam int NBANKS = 2;
  localparam int IDX_W = $clog2(BANK_WORDS);
  localparam int MEM_AW = IDX_W + 1;

  // address decode shared by the write path and the read path
  function automatic logic bank_hit(input logic [`ID_AUTH_ADDR_W-1:0] addr,
                                    input logic [`ID_AUTH_ADDR_W-1:0] base);
    bank_hit = (addr >= base) && (addr < 8'(base + `ID_AUTH_BANK_SPAN)) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic [IDX_W-1:0] word_index(input logic [`ID_AUTH_ADDR_W-1:0] addr);
    word_index = addr[IDX_W+1:2];
  endfunction

  // bus state
  id_auth_pkg::bus_state_t state_q;
  id_auth_pkg::bus_state_t state_d;
  logic [`ID_AUTH_ADDR_W-1:0] addr_q;
  logic [`ID_AUTH_ADDR_W-1:0] addr_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  // decoded write strobes
  logic wr_df;
  logic wr_debug;
  logic wr_ctrl;
  logic full_word;
  logic [IDX_W-1:0] wr_idx;
  logic [NBANKS-1:0] bank_wr;
  logic [NBANKS-1:0] bank_match;
  logic [NBANKS-1:0] bank_restart;
  logic [NBANKS-1:0] bank_done;
  logic [NBANKS-1:0] bank_pass;
  logic [NBANKS-1:0] bank_busy;
  logic [WORD_BITS-1:0] df_ref_word;
  logic [WORD_BITS-1:0] debug_ref_word;

  // memory ports
  logic mem_wr_en;
  logic [MEM_AW-1:0] mem_wr_addr;
  logic mem_rd_en;
  logic [MEM_AW-1:0] mem_rd_addr;
  logic [WORD_BITS-1:0] mem_rd_data;

  // read side decode on the held address
  logic rd_df;
  logic rd_debug;
  logic [31:0] status_word;

  // write decode: a write is taken in the idle state with no wait
  always_comb
  begin
    wr_df = 1'b0;
    wr_debug = 1'b0;
    wr_ctrl = 1'b0;
    full_word = (byteenable == `ID_AUTH_FULL_WORD_BE);
    wr_idx = word_index(address);
    if (write && (state_q == id_auth_pkg::BUS_IDLE))
    begin
      if (bank_hit(address, `ID_AUTH_DF_KEY_BASE))
      begin
        wr_df = full_word;
      end
      else if (bank_hit(address, `ID_AUTH_DEBUG_KEY_BASE))
      begin
        // partial lanes are dropped, the access still completes
        wr_debug = full_word;
      end
      else if (address == `ID_AUTH_CONTROL_OFS)
      begin
        wr_ctrl = byteenable[0];
      end
    end
  end

  // per-word compare against the matching slice of the reference
  always_comb
  begin
    df_ref_word = df_reference_id[32*wr_idx +: 32];
    debug_ref_word = debug_reference_id[32*wr_idx +: 32];
    bank_wr[id_auth_pkg::BANK_DF] = wr_df;
    bank_wr[id_auth_pkg::BANK_DEBUG] = wr_debug;
    bank_match[id_auth_pkg::BANK_DF] = (writedata == df_ref_word);
    bank_match[id_auth_pkg::BANK_DEBUG] = (writedata == debug_ref_word);
    bank_restart[id_auth_pkg::BANK_DF] = wr_ctrl && writedata[`ID_AUTH_CTRL_DF_RESTART];
    bank_restart[id_auth_pkg::BANK_DEBUG] = wr_ctrl && writedata[`ID_AUTH_CTRL_DEBUG_RESTART];
  end

  // one sequence tracker for each bank
  generate
    for (genvar b = 0; b < NBANKS; b++)
    begin : g_bank
      key_order_tracker u_tracker
      (
        .mclk(mclk),
        .resetn(resetn),
        .restart(bank_restart[b]),
        .wr_stb(bank_wr[b]),
        .wr_index(wr_idx),
        .wr_match(bank_match[b]),
        .auth_done(bank_done[b]),
        .auth_pass(bank_pass[b]),
        .auth_busy(bank_busy[b])
      );
    end
  endgenerate

  // word storage for readback, bank number above the word index
  always_comb
  begin
    mem_wr_en = wr_df || wr_debug;
    mem_wr_addr = {wr_debug, wr_idx};
    mem_rd_en = read && (state_q == id_auth_pkg::BUS_IDLE);
    mem_rd_addr = {bank_hit(address, `ID_AUTH_DEBUG_KEY_BASE), word_index(address)};
  end

  key_word_store
  #(
    .WIDTH(WORD_BITS),
    .DEPTH(NBANKS * BANK_WORDS),
    .AW(MEM_AW)
  )
  u_store
  (
    .mclk(mclk),
    .resetn(resetn),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(writedata),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  // status word seen by software
  always_comb
  begin
    status_word = `ID_AUTH_STATUS_RESET;
    status_word[`ID_AUTH_STAT_DF_DONE] = bank_done[id_auth_pkg::BANK_DF];
    status_word[`ID_AUTH_STAT_DF_PASS] = bank_pass[id_auth_pkg::BANK_DF];
    status_word[`ID_AUTH_STAT_DF_BUSY] = bank_busy[id_auth_pkg::BANK_DF];
    status_word[`ID_AUTH_STAT_DEBUG_DONE] = bank_done[id_auth_pkg::BANK_DEBUG];
    status_word[`ID_AUTH_STAT_DEBUG_PASS] = bank_pass[id_auth_pkg::BANK_DEBUG];
    status_word[`ID_AUTH_STAT_DEBUG_BUSY] = bank_busy[id_auth_pkg::BANK_DEBUG];
  end

  // read state machine: memory read, then answer from a flop
  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    readdata_d = readdata_q;
    rd_df = bank_hit(addr_q, `ID_AUTH_DF_KEY_BASE);
    rd_debug = bank_hit(addr_q, `ID_AUTH_DEBUG_KEY_BASE);
    case (state_q)
      id_auth_pkg::BUS_IDLE:
      begin
        if (read)
        begin
          addr_d = address;
          state_d = id_auth_pkg::BUS_RD_MEM;
        end
      end
      id_auth_pkg::BUS_RD_MEM:
      begin
        if (rd_df || rd_debug)
        begin
          readdata_d = mem_rd_data;
        end
        else if (addr_q == `ID_AUTH_STATUS_OFS)
        begin
          readdata_d = status_word;
        end
        else
        begin
          readdata_d = 32'h0000_0000;
        end
        state_d = id_auth_pkg::BUS_RD_DONE;
      end
      id_auth_pkg::BUS_RD_DONE:
      begin
        state_d = id_auth_pkg::BUS_IDLE;
      end
      default:
      begin
        state_d = id_auth_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_q <= id_auth_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      readdata_q <= readdata_d;
    end
  end

  // writes never wait; reads wait until the answer flop is loaded
  assign waitrequest = read && (state_q != id_auth_pkg::BUS_RD_DONE);
  assign readdata = readdata_q;

  assign df_auth_done = bank_done[id_auth_pkg::BANK_DF];
  assign df_auth_pass = bank_pass[id_auth_pkg::BANK_DF];
  assign debug_auth_done = bank_done[id_auth_pkg::BANK_DEBUG];
  assign debug_auth_pass = bank_pass[id_auth_pkg::BANK_DEBUG];

endmodule

// ### id_auth_props.sv
// assertions on the identifier input block's bus and verdict ports
// assumes the block's top module ports; bound at the foot of this file
`timescale 1ns/100ps
`include "id_auth_regs.svh"
module id_auth_props
#(
  parameter int ID_BITS = 256,
  parameter int WORD_BITS = 32,
  parameter int BANK_WORDS = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`ID_AUTH_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [ID_BITS-1:0] df_reference_id,
  input wire logic [ID_BITS-1:0] debug_reference_id,
  input wire logic df_auth_done,
  input wire logic df_auth_pass,
  input wire logic debug_auth_done,
  input wire logic debug_auth_pass
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire logic full_wr = write && byteenable == 4'hf;
  wire logic df_last = full_wr && address == `ID_AUTH_DF_KEY_BASE + 8'h1c;
  wire logic dbg_last = full_wr && address == `ID_AUTH_DEBUG_KEY_BASE + 8'h1c;
  wire logic df_word = full_wr && address[7:5] == 3'h1 && address[1:0] == 2'h0 && address[4:2] != 3'h7;
  wire logic dbg_word = full_wr && address[7:5] == 3'h2 && address[1:0] == 2'h0 && address[4:2] != 3'h7;

  chk_write_no_wait: assert property (write |-> !waitrequest) else $error("write stalled");
  chk_read_two_waits: assert property ($rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("read latency wrong");
  chk_df_pass_done: assert property (df_auth_pass |-> df_auth_done) else $error("pass without done");
  chk_df_verdict_held: assert property (df_auth_done && !write |=> df_auth_done && $stable(df_auth_pass))
    else $error("verdict lost");
  chk_df_done_cause: assert property ($rose(df_auth_done) |-> $past(df_last)) else $error("df done early");
  chk_df_ref_match: assert property ($rose(df_auth_pass) |-> $past(writedata) == $past(df_reference_id[255:224]))
    else $error("df pass on mismatch");
  chk_dbg_done_cause: assert property ($rose(debug_auth_done) |-> $past(dbg_last)) else $error("dbg done early");
  chk_dbg_ref_match: assert property ($rose(debug_auth_pass) |-> $past(writedata) == $past(debug_reference_id[255:224]))
    else $error("dbg pass on mismatch");
  chk_dbg_narrow_ignored: assert property (write && address == `ID_AUTH_DEBUG_KEY_BASE + 8'h1c && byteenable != 4'hf
    && !debug_auth_done |=> !debug_auth_done) else $error("narrow write took effect");
  chk_df_rewrite_clears: assert property (df_word |=> !df_auth_done) else $error("rewrite kept verdict");
  chk_dbg_pass_done: assert property (debug_auth_pass |-> debug_auth_done) else $error("dbg pass without done");
  chk_dbg_verdict_held: assert property (debug_auth_done && !write |=> debug_auth_done && $stable(debug_auth_pass))
    else $error("dbg verdict lost");
  chk_dbg_rewrite_clears: assert property (dbg_word |=> !debug_auth_done) else $error("dbg rewrite kept verdict");
endmodule

bind id_auth_input_registers id_auth_props #(.ID_BITS(ID_BITS), .WORD_BITS(WORD_BITS), .BANK_WORDS(BANK_WORDS)) i_props
(
  .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .df_reference_id(df_reference_id),
  .debug_reference_id(debug_reference_id), .df_auth_done(df_auth_done), .df_auth_pass(df_auth_pass),
  .debug_auth_done(debug_auth_done), .debug_auth_pass(debug_auth_pass)
);

// ### testbench.sv
// self-checking bench for the identifier input registers
// assumes the block's Avalon-MM slave port on a 10 MHz clock
`timescale 1ns/100ps
`include "id_auth_regs.svh"
module testbench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [255:0] df_ref = '0;
  logic [255:0] dbg_ref = '0;
  logic [31:0] readdata, rd;
  logic waitrequest, df_done, df_pass, dbg_done, dbg_pass;
  logic [31:0] mem [2][8] = '{default: 32'h0};
  int nxt [2] = '{0, 0};
  bit ok [2], done [2], pass [2], busy [2];
  int n_fail = 0;
  int check_count = 0;
  int b, k;

  id_auth_input_registers i_id_auth_input_registers
  (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .df_reference_id(df_ref),
    .debug_reference_id(dbg_ref), .df_auth_done(df_done), .df_auth_pass(df_pass),
    .debug_auth_done(dbg_done), .debug_auth_pass(dbg_pass)
  );

  initial
    forever #50 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
      @(posedge mclk);
    write <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0)
      @(posedge mclk);
    rd = readdata;
    read <= 1'b0;
  endtask

  task automatic check_out();
    @(negedge mclk);
    check({30'h0, df_done, df_pass}, {30'h0, done[0], pass[0]});
    check({30'h0, dbg_done, dbg_pass}, {30'h0, done[1], pass[1]});
  endtask

  // bus write of one bank word, then model update and verdict compare
  task automatic key_wr(input int bk, input int kw, input logic [31:0] d, input logic [3:0] be);
    logic [255:0] r;
    logic m;
    r = bk ? dbg_ref : df_ref;
    m = d === r[32*kw +: 32];
    bus_write((bk ? `ID_AUTH_DEBUG_KEY_BASE : `ID_AUTH_DF_KEY_BASE) + 8'(4 * kw), d, be);
    if (be == 4'hf)
    begin
      mem[bk][kw] = d;
      done[bk] = 0;
      pass[bk] = 0;
      busy[bk] = (kw != 7);
      if (kw == 0)
      begin
        nxt[bk] = 1;
        ok[bk] = m;
      end
      else if (kw == nxt[bk])
      begin
        nxt[bk] = kw + 1;
        ok[bk] = ok[bk] && m;
      end
      else
        ok[bk] = 0;
      if (kw == 7)
      begin
        done[bk] = 1;
        pass[bk] = ok[bk] && nxt[bk] == 8;
        nxt[bk] = 0;
      end
    end
    check_out();
  endtask

  // full key: word bad corrupted, words sw and sw+1 swapped, narrow write before word nar
  task automatic key_seq(input int bk, input int bad, input int sw, input int nar);
    int j;
    logic [255:0] r;
    r = bk ? dbg_ref : df_ref;
    for (int i = 0; i < 8; i++)
    begin
      j = (i == sw) ? i + 1 : (i == sw + 1) ? i - 1 : i;
      if (i == nar)
        key_wr(bk, j, $urandom, 4'($urandom % 15));
      key_wr(bk, j, r[32*j +: 32] ^ ((j == bad) ? 32'h1 << ($urandom % 32) : 32'h0), 4'hf);
    end
  endtask

  task automatic restart(input int bk);
    bus_write(8'h04, 32'h1 << bk, 4'hf);
    done[bk] = 0;
    pass[bk] = 0;
    ok[bk] = 0;
    nxt[bk] = 0;
    busy[bk] = 0;
    check_out();
  endtask

  task automatic check_regs();
    for (int i = 0; i < 16; i++)
    begin
      bus_read((i < 8 ? `ID_AUTH_DF_KEY_BASE : `ID_AUTH_DEBUG_KEY_BASE) + 8'(4 * (i % 8)));
      check(rd, mem[i / 8][i % 8]);
    end
    bus_read(8'h00);
    check(rd & 32'h707, {21'h0, busy[1], pass[1], done[1], 5'h0, busy[0], pass[0], done[0]});
  endtask

  initial
  begin
    void'($urandom(32'h68ad969b));
    for (k = 0; k < 8; k++)
    begin
      df_ref[32*k +: 32] <= $urandom;
      dbg_ref[32*k +: 32] <= $urandom;
    end
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    bus_write(8'h80, $urandom, 4'hf);
    bus_write(8'h22, $urandom, 4'hf);
    bus_write(8'h00, $urandom, 4'hf);
    check_regs();
    bus_read(8'h80);
    check(rd, 32'h0);
    for (b = 0; b < 2; b++)
    begin
      key_seq(b, 9, 9, 9);
      check_regs();
      key_seq(b, $urandom % 8, 9, 9);
      key_seq(b, 9, $urandom % 7, 9);
      key_seq(b, 9, 9, $urandom % 8);
      key_seq(b, 9, 9, 7);
      for (k = 0; k < 8; k++)
      begin
        if (k == 4)
          restart(b);
        key_wr(b, k, (b ? dbg_ref[32*k +: 32] : df_ref[32*k +: 32]), 4'hf);
      end
      key_wr(b, 7, (b ? dbg_ref[255:224] : df_ref[255:224]), 4'hf);
      key_seq(b, 9, 9, 9);
      restart(b);
    end
    key_seq(0, 9, 9, 9);
    key_seq(1, 9, 9, 9);
    check_regs();
    // second reset in mid-run must drop both verdicts and all stored words
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    mem = '{default: 32'h0};
    nxt = '{0, 0};
    ok = '{0, 0};
    done = '{0, 0};
    pass = '{0, 0};
    busy = '{0, 0};
    check_out();
    check_regs();
    tally_and_finish();
  end

  initial
  begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
endmodule
